// ---- common/host_port_map.svh ----
// constants of the host bus command port: strap codes, commands, glyph mapping
// ----------------------------------------------------------------------------
// Notes on behaviour
// - separate strobes: read with select high, data write select low, command high
// - enable style: enable high, direction high reads, low writes data or command
// - data strobe low: direction high reads, low writes data or command by select
// - static straps choose which of three bus styles the two strobe pins follow
// - with font ROM, codes 80h-9Fh and E0h-FFh fetch from glyph RAM
// - without font ROM every code uses glyph RAM; host sets base to zero
// - command 5Ch takes low then high byte as glyph RAM base
// - command 4Ch selects rightward cursor advance after each memory write
// - command 46h takes low then high byte as the 16-bit cursor
// - fetch address is base plus shifted character code plus glyph row
// - short glyphs shift code by three with 3-bit row; tall by four
// ----------------------------------------------------------------------------
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// ----------------------------------------------------------------------------
// strap codes for the bus style
// ----------------------------------------------------------------------------
`define STRAP_SEPARATE    3'h0
`define STRAP_ENABLE      3'h1
`define STRAP_DATA_STROBE 3'h2
`define STRAP_SETTLE      2'h2

// ----------------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------------
`define CMD_GLYPH_BASE    8'h5c
`define CMD_CURSOR_DIR    8'h4c
`define CMD_CURSOR_WRITE  8'h46
`define CMD_MEMORY_WRITE  8'h42

// ----------------------------------------------------------------------------
// glyph code ranges and shifts
// ----------------------------------------------------------------------------
`define GLYPH_ONE_FIRST   8'h80
`define GLYPH_ONE_LAST    8'h9f
`define GLYPH_TWO_FIRST   8'he0
`define GLYPH_TWO_LAST    8'hff
`define GLYPH_SHIFT_SHORT 3
`define GLYPH_SHIFT_TALL  4
`define CURSOR_RESET      16'h0000
`define BASE_RESET        16'h0000

`endif

// ---- common/host_port_pkg.sv ----
// types shared by the host bus command port
package host_port_pkg;

    typedef enum logic [1:0] {
        STYLE_SEPARATE    = 2'h0,
        STYLE_ENABLE      = 2'h1,
        STYLE_DATA_STROBE = 2'h2
    } bus_style_e;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_BASE_LO = 3'b001,
        ST_BASE_HI = 3'b011,
        ST_CSR_LO  = 3'b010,
        ST_CSR_HI  = 3'b110,
        ST_MEM_WR  = 3'b111
    } cmd_state_e;

    typedef struct packed {
        logic       isCmd;
        logic [7:0] data;
    } host_word_s;

    typedef struct packed {
        logic [7:0] code;
        logic [3:0] row;
        logic       tall;
        logic       romUsed;
    } glyph_req_s;

endpackage : host_port_pkg

// ---- hw/sync_fifo.sv ----
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;

    wire push = inValid && inReady;
    wire pop  = outValid && outReady;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = store[rdPtr];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage has no reset; read only where count says it is filled
    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end
endmodule : sync_fifo
`default_nettype wire

// ---- hw/glyph_addr_gen.sv ----
// glyph ram selection and fetch address for one character row
`timescale 1ns/100ps
`default_nettype none
`include "host_port_map.svh"
module glyph_addr_gen (
    input  wire host_port_pkg::glyph_req_s req,
    input  wire logic [15:0]               glyphBase,
    output logic                           fromRam,
    output logic      [15:0]               fetchAddr
);
    import host_port_pkg::*;

    wire inRegionOne = (req.code >= `GLYPH_ONE_FIRST) && (req.code <= `GLYPH_ONE_LAST);
    wire inRegionTwo = (req.code >= `GLYPH_TWO_FIRST) && (req.code <= `GLYPH_TWO_LAST);
    // codes outside the ranges come from the font rom when it is in use
    assign fromRam = !req.romUsed || inRegionOne || inRegionTwo;

    wire [15:0] codeShort = {8'h00, req.code} << `GLYPH_SHIFT_SHORT;
    wire [15:0] codeTall  = {8'h00, req.code} << `GLYPH_SHIFT_TALL;
    wire [15:0] rowShort  = {13'h0000, req.row[2:0]};
    wire [15:0] rowTall   = {12'h000, req.row};
    wire [15:0] codePart  = req.tall ? codeTall : codeShort;
    wire [15:0] rowPart   = req.tall ? rowTall : rowShort;

    assign fetchAddr = glyphBase + codePart + rowPart;
endmodule : glyph_addr_gen
`default_nettype wire

// ---- hw/host_bus_command_port.sv ----
// host-side parallel command port with glyph ram address mapping
`timescale 1ns/100ps
`default_nettype none
`include "host_port_map.svh"
module host_bus_command_port #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic [2:0]                 busTypeStraps,
    input  wire logic                       hostStrobeA,
    input  wire logic                       hostStrobeB,
    input  wire logic                       cmdDataSelect,
    input  wire logic [7:0]                 hostDataIn,
    output logic      [7:0]                 hostDataOut,
    output logic                            hostDataOe,
    output logic                            hostWait,
    output logic                            memWrEn,
    output logic      [15:0]                memWrAddr,
    output logic      [7:0]                 memWrData,
    input  wire logic                       memWrReady,
    output logic      [15:0]                memRdAddr,
    input  wire logic [7:0]                 memRdData,
    input  wire host_port_pkg::glyph_req_s  glyphReq,
    output logic                            glyphFromRam,
    output logic      [15:0]                glyphFetchAddr,
    output logic      [15:0]                glyphBase,
    output logic                            cursorRight
);
    import host_port_pkg::*;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    localparam int PINS = 14;

    logic [PINS-1:0] pinMeta;
    logic [PINS-1:0] pinSync;

    wire [PINS-1:0] pinRaw = {busTypeStraps, hostStrobeA, hostStrobeB,
                              cmdDataSelect, hostDataIn};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end

    wire [2:0] strapSync = pinSync[13:11];
    wire       strobeA   = pinSync[10];
    wire       strobeB   = pinSync[9];
    wire       selSync   = pinSync[8];
    wire [7:0] dataSync  = pinSync[7:0];

    // ------------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------------
    // straps are static: caught once after the synchroniser has settled
    logic [1:0] strapCount;
    logic       strapDone;
    bus_style_e busStyle;

    wire strapTake = !strapDone && (strapCount == `STRAP_SETTLE);

    wire bus_style_e strapStyle =
        (strapSync == `STRAP_ENABLE)      ? STYLE_ENABLE :
        (strapSync == `STRAP_DATA_STROBE) ? STYLE_DATA_STROBE :
                                            STYLE_SEPARATE;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strapCount <= '0;
            strapDone  <= 1'b0;
            busStyle   <= STYLE_SEPARATE;
        end else if (!strapDone) begin
            strapCount <= strapCount + 2'h1;
            if (strapTake) begin
                busStyle  <= strapStyle;
                strapDone <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------------
    // pin A: read strobe, enable or data strobe; pin B: write strobe or direction
    wire sepRead  = selSync && !strobeA && strobeB;
    wire sepWrite = strobeA && !strobeB;
    wire enRead   = strobeA && strobeB;
    wire enWrite  = strobeA && !strobeB;
    wire dsRead   = !strobeA && strobeB;
    wire dsWrite  = !strobeA && !strobeB;

    wire styleSep = (busStyle == STYLE_SEPARATE);
    wire styleEn  = (busStyle == STYLE_ENABLE);
    wire styleDs  = (busStyle == STYLE_DATA_STROBE);

    wire readAct  = strapDone && ((styleSep && sepRead) || (styleEn && enRead)
                                  || (styleDs && dsRead));
    wire writeAct = strapDone && ((styleSep && sepWrite) || (styleEn && enWrite)
                                  || (styleDs && dsWrite));

    logic writeActPrev;
    wire  writeStart = writeAct && !writeActPrev;

    // select high marks a command, low a data or parameter byte
    wire host_word_s pushWord = '{isCmd: selSync, data: dataSync};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            writeActPrev <= 1'b0;
        end else begin
            writeActPrev <= writeAct;
        end
    end

    // ------------------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------------------
    logic       fifoInReady;
    logic       fifoOutValid;
    host_word_s fifoOut;

    // a stalled memory write holds the fifo; the host sees wait raised once the fifo is full
    wire fifoOutReady = !memWrEn || memWrReady;
    wire pop          = fifoOutValid && fifoOutReady;

    sync_fifo #(
        .WIDTH ($bits(host_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) writeBuffer (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .inValid  (writeStart),
        .inReady  (fifoInReady),
        .inData   (pushWord),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    // ------------------------------------------------------------------------
    // command interpreter
    // ------------------------------------------------------------------------
    cmd_state_e  state;
    cmd_state_e  next_state;
    logic [15:0] cursor;
    logic [15:0] next_cursor;
    logic [15:0] next_glyphBase;
    logic        next_cursorRight;
    logic        next_memWrEn;
    logic [15:0] next_memWrAddr;
    logic [7:0]  next_memWrData;

    wire popCmd  = pop && fifoOut.isCmd;
    wire popData = pop && !fifoOut.isCmd;

    always_comb begin
        next_state       = state;
        next_cursor      = cursor;
        next_glyphBase   = glyphBase;
        next_cursorRight = cursorRight;
        next_memWrEn     = memWrEn && !memWrReady;
        next_memWrAddr   = memWrAddr;
        next_memWrData   = memWrData;
        if (popCmd) begin
            case (fifoOut.data)
                `CMD_GLYPH_BASE: begin
                    next_state = ST_BASE_LO;
                end
                `CMD_CURSOR_WRITE: begin
                    next_state = ST_CSR_LO;
                end
                `CMD_MEMORY_WRITE: begin
                    next_state = ST_MEM_WR;
                end
                `CMD_CURSOR_DIR: begin
                    next_cursorRight = 1'b1;
                    next_state       = ST_IDLE;
                end
                default: begin
                    // unknown commands end any open parameter sequence
                    next_state = ST_IDLE;
                end
            endcase
        end else if (popData) begin
            case (state)
                ST_BASE_LO: begin
                    next_glyphBase[7:0] = fifoOut.data;
                    next_state          = ST_BASE_HI;
                end
                ST_BASE_HI: begin
                    next_glyphBase[15:8] = fifoOut.data;
                    next_state           = ST_IDLE;
                end
                ST_CSR_LO: begin
                    next_cursor[7:0] = fifoOut.data;
                    next_state       = ST_CSR_HI;
                end
                ST_CSR_HI: begin
                    next_cursor[15:8] = fifoOut.data;
                    next_state        = ST_IDLE;
                end
                ST_MEM_WR: begin
                    next_memWrEn   = 1'b1;
                    next_memWrAddr = cursor;
                    next_memWrData = fifoOut.data;
                    // only rightward advance is implemented here
                    if (cursorRight) begin
                        next_cursor = cursor + 16'h0001;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state       <= ST_IDLE;
            cursor      <= `CURSOR_RESET;
            glyphBase   <= `BASE_RESET;
            cursorRight <= 1'b0;
            memWrEn     <= 1'b0;
            memWrAddr   <= `CURSOR_RESET;
            memWrData   <= 8'h00;
        end else begin
            state       <= next_state;
            cursor      <= next_cursor;
            glyphBase   <= next_glyphBase;
            cursorRight <= next_cursorRight;
            memWrEn     <= next_memWrEn;
            memWrAddr   <= next_memWrAddr;
            memWrData   <= next_memWrData;
        end
    end

    // ------------------------------------------------------------------------
    // host read path and wait
    // ------------------------------------------------------------------------
    // read data lags the strobe by the synchroniser plus one cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hostDataOut <= 8'h00;
            hostDataOe  <= 1'b0;
            hostWait    <= 1'b0;
            memRdAddr   <= `CURSOR_RESET;
        end else begin
            if (readAct) begin
                hostDataOut <= memRdData;
            end
            hostDataOe <= readAct;
            hostWait   <= !fifoInReady;
            memRdAddr  <= next_cursor;
        end
    end

    // ------------------------------------------------------------------------
    // glyph fetch address
    // ------------------------------------------------------------------------
    logic        glyphFromRamComb;
    logic [15:0] glyphAddrComb;

    glyph_addr_gen glyphMap (
        .req       (glyphReq),
        .glyphBase (glyphBase),
        .fromRam   (glyphFromRamComb),
        .fetchAddr (glyphAddrComb)
    );

    // the host keeps one bit per pixel while user glyphs are shown
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            glyphFromRam   <= 1'b0;
            glyphFetchAddr <= 16'h0000;
        end else begin
            glyphFromRam   <= glyphFromRamComb;
            glyphFetchAddr <= glyphAddrComb;
        end
    end

endmodule : host_bus_command_port
`default_nettype wire

// ---- bench/host_port_chk.sv ----
// concurrent checks on the host bus command port pins
`timescale 1ns/100ps
`default_nettype none
module host_port_chk #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic [2:0]                busTypeStraps,
    input  wire logic                      hostStrobeA,
    input  wire logic                      hostStrobeB,
    input  wire logic                      cmdDataSelect,
    input  wire logic                      hostDataOe,
    input  wire logic                      memWrEn,
    input  wire logic [15:0]               memWrAddr,
    input  wire logic [7:0]                memWrData,
    input  wire logic                      memWrReady,
    input  wire host_port_pkg::glyph_req_s glyphReq,
    input  wire logic                      glyphFromRam,
    input  wire logic [15:0]               glyphFetchAddr,
    input  wire logic [15:0]               glyphBase,
    input  wire logic                      cursorRight
);
    import host_port_pkg::*;
    // ------------------------------------------------------------
    // strobe decode per bus style
    // ------------------------------------------------------------
    logic        enSt, dsSt, rdCond, wrCond, stbIdle, selExp;
    logic [15:0] shortAddr, tallAddr;
    assign enSt      = (busTypeStraps == 3'h1);
    assign dsSt      = (busTypeStraps == 3'h2);
    assign rdCond    = enSt ? (hostStrobeA && hostStrobeB)
                     : (!hostStrobeA && hostStrobeB && (dsSt || cmdDataSelect));
    assign wrCond    = !hostStrobeB && (enSt ? hostStrobeA : (dsSt ^ hostStrobeA));
    assign stbIdle   = enSt ? !hostStrobeA : hostStrobeA;
    // code bits 7:5 of 100 or 111 mark the two user glyph ranges
    assign selExp    = !glyphReq.romUsed || glyphReq.code[7:5] == 3'h4
                     || glyphReq.code[7:5] == 3'h7;
    assign shortAddr = glyphBase + {5'h0, glyphReq.code, 3'h0} + {13'h0, glyphReq.row[2:0]};
    assign tallAddr  = glyphBase + {4'h0, glyphReq.code, 4'h0} + {12'h0, glyphReq.row};
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence readHeld;
        rdCond [*6];
    endsequence
    sequence writeHeld;
        wrCond [*5];
    endsequence
    sequence acceptThenWrite;
        memWrEn && memWrReady ##1 memWrEn;
    endsequence
    chk_read_drives: assert property (readHeld |-> hostDataOe)
        else $error("read held but data not driven");
    chk_write_quiet: assert property (writeHeld |-> !hostDataOe)
        else $error("data driven during a write");
    chk_idle_release: assert property (stbIdle [*5] |-> !hostDataOe)
        else $error("data drive stays with strobes idle");
    chk_wr_hold: assert property (memWrEn && !memWrReady
        |=> memWrEn && $stable(memWrAddr) && $stable(memWrData))
        else $error("stalled memory write changed");
    chk_wr_step: assert property (acceptThenWrite
        |-> memWrAddr == $past(memWrAddr) + {15'h0, cursorRight})
        else $error("cursor step wrong between writes");
    // registered outputs still hold reset values one edge after release
    chk_glyph_sel: assert property (!$past(rst)
        |=> glyphFromRam == $past(selExp))
        else $error("glyph source wrong");
    chk_glyph_short: assert property (!$past(rst) && !glyphReq.tall
        |=> glyphFetchAddr == $past(shortAddr))
        else $error("short glyph address wrong");
    chk_glyph_tall: assert property (!$past(rst) && glyphReq.tall
        |=> glyphFetchAddr == $past(tallAddr))
        else $error("tall glyph address wrong");
endmodule : host_port_chk
bind host_bus_command_port host_port_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_host_port_chk (
    .clk_sys, .rst, .busTypeStraps, .hostStrobeA, .hostStrobeB, .cmdDataSelect,
    .hostDataOe, .memWrEn, .memWrAddr, .memWrData, .memWrReady, .glyphReq,
    .glyphFromRam, .glyphFetchAddr, .glyphBase, .cursorRight);
`default_nettype wire

// ---- bench/host_cpu_model.sv ----
// host processor model driving the parallel strobe pins
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
    input  wire logic       clk_sys,
    input  wire logic [2:0] busTypeStraps,
    input  wire logic       hostDataOe,
    input  wire logic [7:0] hostDataOut,
    output logic            hostStrobeA,
    output logic            hostStrobeB,
    output logic            cmdDataSelect,
    output logic      [7:0] hostDataIn
);
    logic en;
    assign en = (busTypeStraps == 3'h1);
    initial begin
        hostStrobeA   = 1'b1;
        hostStrobeB   = 1'b1;
        cmdDataSelect = 1'b0;
        hostDataIn    = 8'h00;
    end
    task automatic idle();
        hostStrobeA <= !en;
        hostStrobeB <= 1'b1;
    endtask : idle
    // select and data held 5 cycles, then 5 idle cycles before the next access
    task automatic wr(input logic c, input logic [7:0] d);
        @(posedge clk_sys);
        cmdDataSelect <= c;
        hostDataIn    <= d;
        hostStrobeA   <= (busTypeStraps != 3'h2);
        hostStrobeB   <= 1'b0;
        repeat (5) @(posedge clk_sys);
        idle();
        hostDataIn <= ~d; // released bus must not look like the last byte
        repeat (5) @(posedge clk_sys);
    endtask : wr
    task automatic rd(output logic [7:0] v, output logic seen);
        int n;
        @(posedge clk_sys);
        cmdDataSelect <= 1'b1;
        hostStrobeA   <= en;
        hostStrobeB   <= 1'b1;
        n = 0;
        while (hostDataOe !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (2) @(posedge clk_sys);
        v    = hostDataOut;
        seen = hostDataOe;
        idle();
        repeat (5) @(posedge clk_sys);
    endtask : rd
endmodule : host_cpu_model
`default_nettype wire

// ---- bench/tb_host_bus_command_port.sv ----
// self-checking bench for the host bus command port
`timescale 1ns/100ps
`default_nettype none
module tb_host_bus_command_port;
    import host_port_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, stall = 1'b0, memWrReady = 1'b0;
    logic [2:0]  busTypeStraps = 3'h0;
    logic        hostStrobeA, hostStrobeB, cmdDataSelect, hostDataOe, hostWait;
    logic        memWrEn, glyphFromRam, cursorRight, oeSeen;
    logic [7:0]  hostDataIn, hostDataOut, memWrData, rv, memRdData = 8'h00;
    logic [15:0] memWrAddr, memRdAddr, glyphFetchAddr, glyphBase;
    glyph_req_s  glyphReq = '0;
    logic [23:0] expQ[$];
    int          miscompares = 0, num_checks = 0, seed = 28059, cur, base, cnt, n;

    host_bus_command_port #(.FIFO_DEPTH(8)) u_host_bus_command_port (
        .clk_sys, .rst, .busTypeStraps, .hostStrobeA, .hostStrobeB, .cmdDataSelect,
        .hostDataIn, .hostDataOut, .hostDataOe, .hostWait, .memWrEn, .memWrAddr,
        .memWrData, .memWrReady, .memRdAddr, .memRdData, .glyphReq, .glyphFromRam,
        .glyphFetchAddr, .glyphBase, .cursorRight);
    host_cpu_model u_host_cpu_model (
        .clk_sys, .busTypeStraps, .hostDataOe, .hostDataOut, .hostStrobeA,
        .hostStrobeB, .cmdDataSelect, .hostDataIn);

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) memWrReady <= !stall & 1'($random(seed));
    // ------------------------------------------------------------
    // memory side monitor against the expected write queue
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (memWrEn === 1'b1 && memWrReady === 1'b1) begin
            if (expQ.size() == 0) check("extra write", 1, 0);
            else check("write", {memWrAddr, memWrData}, expQ.pop_front());
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic do_reset(input logic [2:0] s);
        rst           <= 1'b1;
        busTypeStraps <= s;
        repeat (16) @(posedge clk_sys);
        u_host_cpu_model.idle();
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : do_reset
    task automatic cmd3(input logic [7:0] c, input logic [15:0] v);
        u_host_cpu_model.wr(1'b1, c);
        u_host_cpu_model.wr(1'b0, v[7:0]);
        u_host_cpu_model.wr(1'b0, v[15:8]);
    endtask : cmd3
    task automatic put_byte();
        rv = 8'($random(seed));
        expQ.push_back({cur[15:0], rv});
        cur = (cur + 1) % 65536;
        u_host_cpu_model.wr(1'b0, rv);
    endtask : put_byte
    task automatic drain();
        cnt = 0;
        while (expQ.size() != 0 && cnt < 300) begin
            @(posedge clk_sys);
            cnt++;
        end
        repeat (3) @(posedge clk_sys);
        check("writes left", expQ.size(), 0);
    endtask : drain
    // no grey depth is ever set here: the host stays at one bit per pixel
    task automatic glyph_test();
        logic [7:0] c;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            glyphReq <= glyph_req_s'(14'($random(seed)));
            @(posedge clk_sys);
            #1;
            c = glyphReq.code;
            check("from ram", glyphFromRam, !glyphReq.romUsed
                || (c >= 8'h80 && c <= 8'h9f) || c >= 8'he0);
            check("fetch", glyphFetchAddr, glyphReq.tall
                ? (base + c * 16 + glyphReq.row) % 65536
                : (base + c * 8 + glyphReq.row % 8) % 65536);
        end
    endtask : glyph_test
    // ------------------------------------------------------------
    // main sequence: one pass per bus style, then a stalled fill
    // ------------------------------------------------------------
    initial begin
        for (int s = 0; s < 3; s++) begin
            do_reset(3'(s));
            check("reset base", glyphBase, 0);
            check("reset dir", cursorRight, 0);
            base = (s == 2) ? 0 : ($random(seed) & 32'h0000ffff);
            cur  = $random(seed) & 32'h0000ffff;
            cmd3(8'h5c, base[15:0]);
            u_host_cpu_model.wr(1'b1, 8'h4c);
            cmd3(8'h46, cur[15:0]);
            check("glyph base", glyphBase, base);
            check("cursor dir", cursorRight, 1);
            check("cursor", memRdAddr, cur);
            u_host_cpu_model.wr(1'b1, 8'h42);
            for (int k = 0; k < 4 + s; k++) put_byte();
            drain();
            memRdData <= 8'($random(seed));
            u_host_cpu_model.rd(rv, oeSeen);
            check("read drive", oeSeen, 1);
            check("read data", rv, memRdData);
            glyph_test();
            $display("style %0d test done", s);
        end
        stall <= 1'b1;
        u_host_cpu_model.wr(1'b1, 8'h42);
        n = 0;
        while (hostWait !== 1'b1 && n < 20) begin
            put_byte();
            n++;
        end
        check("wait", hostWait, 1);
        check("bytes taken", n, 9); // fifo depth plus the one held on memory side
        stall <= 1'b0;
        drain();
        $display("stall test done");
        end_sim();
    end
    initial begin
        #100000;
        check("watchdog", 0, 1);
        end_sim();
    end
endmodule : tb_host_bus_command_port
`default_nettype wire
